// file: low_power_mode_controller_test.sv
// Bench for lpmc_ctrl: registers, all modes and their wake paths except the gpio wake from the two sleep modes.
// Assumes lpmc_env_model as core and wake sources.
`timescale 1ns/1ps
module low_power_mode_controller_test;
   import lpmc_pkg::*;
   localparam int SC = 20;
   typedef struct packed { logic [1:0] vr; logic [15:0] f; } lpmc_row_s;
   lpmc_row_s rows [4] = '{'{2'h1, R1_MAX_KHZ}, '{2'h2, R2_MAX_KHZ}, '{2'h3, R3_MAX_KHZ}, '{2'h0, R3_MAX_KHZ}};
   int src_bit [3] = '{RC_WKPIN, RC_INDEPENDENT_WATCHDOG, RC_RTC};
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic sleep_go = 1'h0, irq_go = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq, sleep_req, periph_irq;
   logic [1:0] bresp, rresp, vr, rs;
   logic [31:0] rdata, rd;
   logic [15:0] fmax;
   lpmc_wake_s ev = 23'h000002;
   lpmc_wake_s wake_in;
   lpmc_pwr_s pwr;
   int fail_count = 0, checked = 0, n;
   // Clock at 200 MHz
   always #2.5 aclk = ~aclk;
   lpmc_ctrl #(.STBY_CYC(SC)) lpmc_ctrl_i (.aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sleep_req, .periph_irq, .wake_in,
      .pwr, .vrange(vr), .cpu_fmax_khz(fmax), .irq);
   lpmc_env_model lpmc_env_model_i (.aclk, .sleep_go, .irq_go, .ev, .sleep_req, .periph_irq, .wake_in);
   // Compares one value and counts it
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("Checks %0d, mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One AXI4-Lite write or read, held until its answer
   task automatic bus(input bit wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge aclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awvalid <= wr;
      wvalid <= wr;
      bready <= wr;
      arvalid <= !wr;
      rready <= !wr;
      do begin
         @(posedge aclk);
         k++;
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      end while (!(wr ? bvalid === 1'h1 : rvalid === 1'h1) && k < 50);
      rs = wr ? bresp : rresp;
      rd = rdata;
      bready <= 1'h0;
      rready <= 1'h0;
      if (k >= 50) begin
         fail_count++;
         results;
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Waits, bounded, until the CPU clock runs out of reset
   task automatic wait_run(input int lim);
      n = 0;
      while (!(pwr.cpu_clk_en === 1'h1 && pwr.core_rst_n === 1'h1) && n < lim) begin
         @(posedge aclk);
         n++;
      end
      if (n >= lim) begin
         fail_count++;
         results;
      end
   endtask
   // Selects a mode, then the core asks for it
   task automatic enter(input logic [31:0] c);
      bus(1'b1, OFS_CTRL, c);
      sleep_go <= 1'h1;
      repeat (4) @(posedge aclk);
      sleep_go <= 1'h0;
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge aclk);
      chk(pwr, PWR_RUN);
      chk(fmax, R2_MAX_KHZ);
      chk(irq, 1'h0);
      aresetn <= 1'h1;
      rchk(OFS_CTRL, 32'h22);
      rchk(OFS_IMASK, 32'h0);
      bus(1'b1, OFS_STATUS, 32'hF);
      rchk(OFS_STATUS, 32'h20);
      rchk(12'h100, 32'h0);
      chk(rs, RESP_SLVERR);
      bus(1'b1, 12'h100, 32'h1);
      chk(rs, RESP_SLVERR);
      foreach (rows[i]) begin
         bus(1'b1, OFS_CTRL, {30'h8, rows[i].vr});
         repeat (2) @(posedge aclk);
         chk(vr, rows[i].vr);
         chk(fmax, rows[i].f);
      end
      enter(32'h22);
      chk({pwr.cpu_clk_en, pwr.core_clk_en}, 2'h1);
      irq_go <= 1'h1;
      wait_run(10);
      irq_go <= 1'h0;
      rchk(OFS_ISTAT, 32'h1);
      bus(1'b1, OFS_IMASK, 32'h7);
      chk(irq, 1'h1);
      bus(1'b1, OFS_ISTAT, 32'h1);
      chk(irq, 1'h0);
      bus(1'b1, OFS_CTRL, 32'h66);
      repeat (3) @(posedge aclk);
      chk({pwr.msi_low, pwr.reg_lp, fmax}, {2'h3, LPRUN_MAX_KHZ});
      enter(32'h66);
      chk({pwr.cpu_clk_en, pwr.reg_lp}, 2'h1);
      irq_go <= 1'h1;
      wait_run(10);
      irq_go <= 1'h0;
      repeat (2) @(posedge aclk);
      chk(pwr.reg_lp, 1'h0);
      rchk(OFS_CTRL, 32'h26);
      bus(1'b1, OFS_ISTAT, 32'h7);
      for (int i = 0; i < 3; i++) begin
         enter(32'h2A);
         chk({pwr.core_clk_en, pwr.pll_en, pwr.msi_en, pwr.ext_clk_en, pwr.hsi_en}, 5'h0);
         chk(pwr.lse_en || pwr.lsi_en, 1'h1);
         ev.hsi_req <= 1'h1;
         repeat (6) @(posedge aclk);
         chk(pwr.hsi_en, 1'h1);
         ev.hsi_req <= 1'h0;
         ev.gpio <= i == 0 ? 8'h80 : 8'h00;
         ev.rtc <= i == 1 ? 5'h01 : 5'h00;
         ev.serial <= i == 2 ? 4'h8 : 4'h0;
         wait_run(800);
         chk(n >= 700 && n <= 710, 1'h1);
         ev <= 23'h000002;
         rchk(OFS_ISTAT, 32'h2);
         bus(1'b1, OFS_ISTAT, 32'h2);
      end
      enter(32'h0A);
      chk(pwr.lse_en || pwr.lsi_en, 1'h0);
      ev.rtc <= 5'h1F;
      repeat (30) @(posedge aclk);
      chk(pwr.cpu_clk_en, 1'h0);
      ev <= 23'h000042;
      wait_run(800);
      ev <= 23'h000002;
      for (int j = 0; j < 3; j++) begin
         bus(1'b1, OFS_ISTAT, 32'h7);
         bus(1'b1, OFS_RCAUSE, 32'hF);
         enter(32'h2E);
         chk({pwr.core_pwr_off, pwr.pll_en, pwr.msi_en, pwr.ext_clk_en, pwr.hsi_en}, 5'h10);
         chk(pwr.lse_en || pwr.lsi_en, 1'h1);
         ev.wake_pin <= j == 0 ? 3'h1 : 3'h0;
         ev.independent_watchdog_rst <= j == 1;
         ev.rtc <= j == 2 ? 5'h02 : 5'h00;
         wait_run(SC + 30);
         chk(n >= SC && n <= SC + 10, 1'h1);
         ev <= 23'h000002;
         rchk(OFS_CTRL, 32'h22);
         rchk(OFS_IMASK, 32'h0);
         rchk(OFS_ISTAT, 32'h4);
         rchk(OFS_RCAUSE, 32'h1 << src_bit[j]);
      end
      enter(32'h0E);
      ev <= 23'h7FFFC3;
      repeat (30) @(posedge aclk);
      chk(pwr.core_pwr_off, 1'h1);
      ev <= 23'h000000;
      repeat (2) @(posedge aclk);
      ev <= 23'h000002;
      wait_run(SC + 30);
      chk(n <= SC + 10, 1'h1);
      bus(1'b0, OFS_RCAUSE, 32'h0);
      chk(rd[RC_PIN], 1'h1);
      results;
   end
   // Cuts a hung run short
   initial begin
      #500000;
      fail_count++;
      results;
   end
endmodule

// file: lpmc_ctrl.sv
// Low-power mode controller: mode state machine, clock and
// regulator controls, wake logic and AXI4-Lite registers.
// Assumes one 200 MHz clock; wake sources are asynchronous pins.
`timescale 1ns/1ps
module lpmc_ctrl
   import lpmc_pkg::*;
#(
   parameter int STBY_CYC = STBY_WAKE_CYC
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic [11:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [11:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic sleep_req, // Core wait-for-interrupt pulse
   input wire logic periph_irq, // Peripheral interrupt or event
   input wire lpmc_wake_s wake_in, // Asynchronous wake sources
   output lpmc_pwr_s pwr, // Clock and regulator controls
   output logic [1:0] vrange, // Active voltage range
   output logic [15:0] cpu_fmax_khz, // CPU clock ceiling
   output logic irq // Level interrupt
);

   // ----------------------------------------
   // State record
   // ----------------------------------------
   typedef struct packed {
      lpmc_wake_s sync1;
      lpmc_wake_s sync2;
      logic [2:0] wkp_d;
      lpmc_state_e st;
      logic [15:0] cnt;
      lpmc_ctrl_s ctrl;
      logic [2:0] imask;
      logic [2:0] istat;
      logic [3:0] rcause;
      lpmc_pwr_s pwr;
      logic [15:0] fmax;
      logic aw_v;
      logic [11:0] aw_a;
      logic w_v;
      logic [31:0] w_d;
      logic [3:0] w_s;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lpmc_q_s;

   lpmc_q_s q_r;
   lpmc_q_s q_nxt;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   // Low-power mode chosen at a wait-for-interrupt
   function automatic lpmc_state_e lpmc_entry(input lpmc_lpm_e m);
      lpmc_state_e s;
      case (m)
         LPM_SLEEP: s = ST_SLEEP;
         LPM_LPSLEEP: s = ST_LPSLEEP;
         LPM_STOP: s = ST_STOP;
         LPM_STBY: s = ST_STBY;
         default: s = ST_SLEEP;
      endcase
      return s;
   endfunction

   // Clock ceiling for a voltage range; code 0 is taken as the lowest
   function automatic logic [15:0] lpmc_fmax(input logic [1:0] vr);
      logic [15:0] f;
      case (vr)
         2'h1: f = R1_MAX_KHZ;
         2'h2: f = R2_MAX_KHZ;
         default: f = R3_MAX_KHZ;
      endcase
      return f;
   endfunction

   // Clock and regulator settings for each state
   function automatic lpmc_pwr_s lpmc_pwr(input lpmc_state_e s, input logic rtc,
                                          input logic hsi_req);
      lpmc_pwr_s p;
      p = PWR_RUN;
      case (s)
         ST_RUN: p = PWR_RUN;
         ST_SLEEP: p.cpu_clk_en = 1'b0;
         ST_LPRUN, ST_LPSLEEP: begin
            p.cpu_clk_en = (s == ST_LPRUN);
            p.pll_en = 1'b0;
            p.hsi_en = 1'b0;
            p.msi_low = 1'b1;
            p.reg_lp = 1'b1;
         end
         ST_STOP, ST_STBY: begin
            p = '0;
            p.lse_en = rtc;
            p.lsi_en = rtc;
            p.reg_lp = 1'b1;
            p.hsi_en = (s == ST_STOP) & hsi_req;
            p.core_pwr_off = (s == ST_STBY);
            p.core_rst_n = (s == ST_STOP);
         end
         ST_STOP_WAKE, ST_STBY_WAKE: begin
            p = '0;
            p.lse_en = rtc;
            p.lsi_en = rtc;
            p.msi_en = 1'b1;
            p.hsi_en = 1'b1;
            p.core_rst_n = (s == ST_STOP_WAKE);
         end
         default: p = PWR_RUN;
      endcase
      return p;
   endfunction

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   logic aw_fire;
   logic w_fire;
   logic wr_do;
   logic ar_fire;
   logic [2:0] wkp_rise;
   logic rtc_any;
   logic stop_wake;
   logic [3:0] stby_cause;
   logic [2:0] ev_set;
   logic [31:0] rd_word;
   logic rd_ok;

   always_comb begin
      q_nxt = q_r;
      ev_set = 3'h0;
      rd_word = 32'h00000000;
      rd_ok = 1'b1;

      // Two-stage synchronisers; the third stage spots wake pin edges
      q_nxt.sync1 = wake_in;
      q_nxt.sync2 = q_r.sync1;
      q_nxt.wkp_d = q_r.sync2.wake_pin;
      wkp_rise = q_r.sync2.wake_pin & ~q_r.wkp_d;

      // Wake source groups
      rtc_any = q_r.ctrl.rtc_on & (|q_r.sync2.rtc);
      stop_wake = (|q_r.sync2.gpio) | (|q_r.sync2.serial) | rtc_any;
      stby_cause = 4'h0;
      stby_cause[RC_PIN] = ~q_r.sync2.rst_pin_n;
      stby_cause[RC_INDEPENDENT_WATCHDOG] = q_r.ctrl.rtc_on & q_r.sync2.independent_watchdog_rst;
      stby_cause[RC_WKPIN] = |wkp_rise;
      stby_cause[RC_RTC] = rtc_any;

      // Write channel: address and data captured in either order
      aw_fire = s_axi_awvalid & ~q_r.aw_v;
      w_fire = s_axi_wvalid & ~q_r.w_v;
      if (aw_fire) begin
         q_nxt.aw_v = 1'b1;
         q_nxt.aw_a = s_axi_awaddr;
      end
      if (w_fire) begin
         q_nxt.w_v = 1'b1;
         q_nxt.w_d = s_axi_wdata;
         q_nxt.w_s = s_axi_wstrb;
      end
      if (q_r.bvalid & s_axi_bready) begin
         q_nxt.bvalid = 1'b0;
      end
      wr_do = q_r.aw_v & q_r.w_v & ~q_r.bvalid;
      if (wr_do) begin
         q_nxt.aw_v = 1'b0;
         q_nxt.w_v = 1'b0;
         q_nxt.bvalid = 1'b1;
         q_nxt.bresp = RESP_OKAY;
         case ({q_r.aw_a[11:2], 2'b00})
            OFS_CTRL: begin
               if (q_r.w_s[0]) begin
                  q_nxt.ctrl = q_r.w_d[6:0];
               end
            end
            OFS_ISTAT: begin
               if (q_r.w_s[0]) begin
                  q_nxt.istat = q_r.istat & ~q_r.w_d[2:0];
               end
            end
            OFS_IMASK: begin
               if (q_r.w_s[0]) begin
                  q_nxt.imask = q_r.w_d[2:0];
               end
            end
            OFS_RCAUSE: begin
               if (q_r.w_s[0]) begin
                  q_nxt.rcause = q_r.rcause & ~q_r.w_d[3:0];
               end
            end
            OFS_STATUS: q_nxt.bresp = RESP_OKAY;
            default: q_nxt.bresp = RESP_SLVERR;
         endcase
      end

      // Read channel: one read answered per handshake
      case ({s_axi_araddr[11:2], 2'b00})
         OFS_CTRL: rd_word = {25'h0, q_r.ctrl};
         OFS_STATUS: rd_word = {26'h0, q_r.ctrl.vrange, q_r.st};
         OFS_ISTAT: rd_word = {29'h0, q_r.istat};
         OFS_IMASK: rd_word = {29'h0, q_r.imask};
         OFS_RCAUSE: rd_word = {28'h0000000, q_r.rcause};
         default: rd_ok = 1'b0;
      endcase
      ar_fire = s_axi_arvalid & ~q_r.rvalid;
      if (q_r.rvalid & s_axi_rready) begin
         q_nxt.rvalid = 1'b0;
      end
      if (ar_fire) begin
         q_nxt.rvalid = 1'b1;
         q_nxt.rdata = rd_word;
         q_nxt.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end

      // Mode state machine
      q_nxt.cnt = q_r.cnt + 16'h0001;
      case (q_r.st)
         ST_RUN: begin
            if (sleep_req) begin
               q_nxt.st = lpmc_entry(q_nxt.ctrl.mode);
            end else if (q_nxt.ctrl.lprun) begin
               q_nxt.st = ST_LPRUN;
            end
         end
         ST_LPRUN: begin
            if (sleep_req) begin
               q_nxt.st = lpmc_entry(q_nxt.ctrl.mode);
            end else if (!q_nxt.ctrl.lprun) begin
               q_nxt.st = ST_RUN;
            end
         end
         ST_SLEEP, ST_LPSLEEP: begin
            if (periph_irq | (|q_r.sync2.gpio)) begin
               q_nxt.st = ST_RUN;
               q_nxt.ctrl.lprun = 1'b0;
               ev_set[IRQ_SLEEP] = 1'b1;
            end
         end
         ST_STOP: begin
            q_nxt.cnt = 16'h0000;
            if (stop_wake) begin
               q_nxt.st = ST_STOP_WAKE;
            end
         end
         ST_STOP_WAKE: begin
            if (q_r.cnt == STOP_WAKE_LAST) begin
               q_nxt.st = ST_RUN;
               q_nxt.ctrl.lprun = 1'b0;
               ev_set[IRQ_STOP] = 1'b1;
            end
         end
         ST_STBY: begin
            q_nxt.cnt = 16'h0000;
            q_nxt.imask = 3'h0;
            if (stby_cause != 4'h0) begin
               q_nxt.st = ST_STBY_WAKE;
               q_nxt.rcause = q_nxt.rcause | stby_cause;
            end
         end
         ST_STBY_WAKE: begin
            if (q_r.cnt == 16'(STBY_CYC - 1)) begin
               q_nxt.st = ST_RUN;
               q_nxt.ctrl = CTRL_RST;
               q_nxt.imask = 3'h0;
               ev_set[IRQ_STBY] = 1'b1;
            end
         end
         default: q_nxt.st = ST_RUN;
      endcase

      // Sticky events; a set in the clearing cycle wins
      q_nxt.istat = q_nxt.istat | ev_set;

      // Registered outputs follow the next state
      q_nxt.pwr = lpmc_pwr(q_nxt.st, q_nxt.ctrl.rtc_on, q_r.sync2.hsi_req);
      q_nxt.fmax = (q_nxt.st == ST_LPRUN || q_nxt.st == ST_LPSLEEP)
                   ? LPRUN_MAX_KHZ : lpmc_fmax(q_nxt.ctrl.vrange);
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q_r <= '0;
         q_r.ctrl <= CTRL_RST;
         q_r.pwr <= PWR_RUN;
         q_r.fmax <= R2_MAX_KHZ;
      end else begin
         q_r <= q_nxt;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   assign s_axi_awready = ~q_r.aw_v;
   assign s_axi_wready = ~q_r.w_v;
   assign s_axi_bvalid = q_r.bvalid;
   assign s_axi_bresp = q_r.bresp;
   assign s_axi_arready = ~q_r.rvalid;
   assign s_axi_rvalid = q_r.rvalid;
   assign s_axi_rdata = q_r.rdata;
   assign s_axi_rresp = q_r.rresp;
   assign pwr = q_r.pwr;
   assign vrange = q_r.ctrl.vrange;
   assign cpu_fmax_khz = q_r.fmax;
   // Interrupt is high while any unmasked status bit is set
   assign irq = |(q_r.istat & q_r.imask);
endmodule

// file: lpmc_ctrl_sva.sv
// Port checker for lpmc_ctrl: clock gating, wake timing, bus holds.
// Assumes a bind to lpmc_ctrl that hands on its STBY_CYC.
`timescale 1ns/1ps
module lpmc_ctrl_sva
   import lpmc_pkg::*;
#(
   parameter int STBY_CYC = 20
) (
   input wire logic aclk, // Clock
   input wire logic aresetn, // Sync reset, active low
   input wire logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [1:0] s_axi_bresp, // Write response
   input wire logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready, // Read data ready
   input wire logic [31:0] s_axi_rdata, // Read data
   input wire logic periph_irq, // Peripheral event
   input wire lpmc_wake_s wake_in, // Wake sources
   input wire lpmc_pwr_s pwr, // Clock and regulator controls
   input wire logic [1:0] vrange, // Active range
   input wire logic [15:0] cpu_fmax_khz // CPU clock ceiling
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic stop_w;
   logic slp_w;
   logic [15:0] hold_cnt_r;
   // Stop has the regulator low, core clocks off, core still powered; sleep only gates the CPU
   assign stop_w = pwr.reg_lp && !pwr.core_clk_en && !pwr.core_pwr_off;
   assign slp_w = !pwr.cpu_clk_en && pwr.core_clk_en;
   // Counts powered cycles with the core held in reset
   always_ff @(posedge aclk) begin
      if (!aresetn || pwr.core_rst_n || pwr.core_pwr_off) begin
         hold_cnt_r <= 16'h0000;
      end else begin
         hold_cnt_r <= hold_cnt_r + 16'h0001;
      end
   end
   sequence s_hsi_held;
      (stop_w && wake_in.hsi_req) [*6];
   endsequence
   sequence s_back_on;
      pwr.cpu_clk_en && !pwr.reg_lp;
   endsequence
   AST_FMAX: assert property (pwr == PWR_RUN |->
      cpu_fmax_khz == (vrange == 2'h1 ? R1_MAX_KHZ : vrange == 2'h2 ? R2_MAX_KHZ : R3_MAX_KHZ))
      else $error("clock ceiling does not match range");
   AST_SLEEP_WAKE: assert property (slp_w && periph_irq |-> ##[1:3] s_back_on)
      else $error("sleep did not end on event");
   AST_LPRUN: assert property (pwr.cpu_clk_en && pwr.reg_lp |->
      pwr.msi_en && pwr.msi_low && cpu_fmax_khz == LPRUN_MAX_KHZ)
      else $error("low-power run clocking wrong");
   AST_STOP_CLKS: assert property (stop_w |->
      !pwr.pll_en && !pwr.ext_clk_en && !pwr.msi_en && !pwr.cpu_clk_en)
      else $error("fast clock left on in stop");
   AST_STOP_HSI: assert property (s_hsi_held |-> pwr.hsi_en)
      else $error("oscillator request ignored in stop");
   AST_STOP_WAKE: assert property (stop_w && wake_in.gpio != 8'h00 |-> ##[1:710] pwr.cpu_clk_en)
      else $error("stop wake too slow");
   AST_STBY_OFF: assert property (pwr.core_pwr_off |->
      !pwr.pll_en && !pwr.ext_clk_en && !pwr.msi_en && !pwr.hsi_en)
      else $error("clock left on in standby");
   AST_STBY_PIN: assert property (pwr.core_pwr_off && $rose(wake_in.wake_pin[0]) |-> ##[1:8] !pwr.core_pwr_off)
      else $error("wake pin did not end standby");
   AST_STBY_RST: assert property ($rose(pwr.core_rst_n) |->
      hold_cnt_r inside {[STBY_CYC - 1 : STBY_CYC + 1]})
      else $error("core reset hold length wrong");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
endmodule

bind lpmc_ctrl lpmc_ctrl_sva #(.STBY_CYC(STBY_CYC)) lpmc_ctrl_sva_i (.aclk, .aresetn, .s_axi_bvalid,
   .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .periph_irq, .wake_in, .pwr,
   .vrange, .cpu_fmax_khz);

// file: lpmc_env_model.sv
// Model of the core and the wake sources facing lpmc_ctrl.
// Assumes the bench changes its requests just after aclk edges.
`timescale 1ns/1ps
module lpmc_env_model
   import lpmc_pkg::*;
(
   input wire logic aclk, // Clock
   input wire logic sleep_go, // Core asked to sleep
   input wire logic irq_go, // Peripheral event asked for
   input wire lpmc_wake_s ev, // Pin levels asked for
   output logic sleep_req, // Core sleep pulse
   output logic periph_irq, // Peripheral event level
   output lpmc_wake_s wake_in // Wake pins
);
   logic go_r;
   // Quiet pins at power-up, reset pin released
   initial begin
      go_r = 1'h0;
      sleep_req = 1'h0;
      periph_irq = 1'h0;
      wake_in = 23'h000002;
   end
   // Core gives one pulse per request; pins follow the asked levels
   always @(posedge aclk) begin
      go_r <= sleep_go;
      sleep_req <= sleep_go && !go_r;
      periph_irq <= irq_go;
      wake_in <= ev;
   end
endmodule

// file: lpmc_pkg.sv
// Package for the low-power mode controller: register map,
// field layouts, reset values, state codes and wake timing.
// Assumes a 200 MHz aclk; imported whole by the controller.
package lpmc_pkg;
   // ----------------------------------------
   // Clock and wake timing
   // ----------------------------------------
   localparam int CLK_NS = 5;
   localparam int STOP_WAKE_NS = 3500;
   localparam int STOP_WAKE_CYC = STOP_WAKE_NS / CLK_NS;
   localparam int STBY_WAKE_US = 60;
   localparam int STBY_WAKE_CYC = STBY_WAKE_US * 1000 / CLK_NS;
   localparam logic [15:0] STOP_WAKE_LAST = 16'(STOP_WAKE_CYC - 1);

   // ----------------------------------------
   // Frequency ceilings in kHz
   // ----------------------------------------
   localparam logic [15:0] R1_MAX_KHZ = 16'h7D00;
   localparam logic [15:0] R2_MAX_KHZ = 16'h3E80;
   localparam logic [15:0] R3_MAX_KHZ = 16'h1068;
   localparam logic [15:0] LPRUN_MAX_KHZ = 16'h0083;

   // ----------------------------------------
   // Register offsets and fields
   // ----------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_ISTAT = 12'h008;
   localparam logic [11:0] OFS_IMASK = 12'h00C;
   localparam logic [11:0] OFS_RCAUSE = 12'h010;
   localparam int IRQ_SLEEP = 0;
   localparam int IRQ_STOP = 1;
   localparam int IRQ_STBY = 2;
   localparam int RC_PIN = 0;
   localparam int RC_INDEPENDENT_WATCHDOG = 1;
   localparam int RC_WKPIN = 2;
   localparam int RC_RTC = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      LPM_SLEEP = 3'h0, LPM_LPSLEEP = 3'h1, LPM_STOP = 3'h2, LPM_STBY = 3'h3
   } lpmc_lpm_e;

   typedef enum logic [3:0] {
      ST_RUN = 4'h0, ST_SLEEP = 4'h1, ST_LPRUN = 4'h2, ST_LPSLEEP = 4'h3,
      ST_STOP = 4'h4, ST_STOP_WAKE = 4'h5, ST_STBY = 4'h6, ST_STBY_WAKE = 4'h7
   } lpmc_state_e;

   // Control register, bit 0 upward: vrange, mode, rtc_on, lprun
   typedef struct packed {
      logic lprun;
      logic rtc_on;
      lpmc_lpm_e mode;
      logic [1:0] vrange;
   } lpmc_ctrl_s;
   localparam lpmc_ctrl_s CTRL_RST = 7'h22;

   // Clock, oscillator and regulator controls
   typedef struct packed {
      logic cpu_clk_en;
      logic core_clk_en;
      logic pll_en;
      logic ext_clk_en;
      logic msi_en;
      logic msi_low;
      logic hsi_en;
      logic lse_en;
      logic lsi_en;
      logic reg_lp;
      logic core_pwr_off;
      logic core_rst_n;
   } lpmc_pwr_s;
   localparam lpmc_pwr_s PWR_RUN = 12'hFB9;

   // Wake sources arriving from outside the clock domain
   typedef struct packed {
      logic [7:0] gpio;
      logic [4:0] rtc;
      logic [3:0] serial;
      logic [2:0] wake_pin;
      logic hsi_req;
      logic rst_pin_n;
      logic independent_watchdog_rst;
   } lpmc_wake_s;
endpackage
